// ### core/dram_ctrl_pkg.sv
// Contract
// - State machine and bus controls follow one 33.33 MHz system rate.
// - Row address is processor bits 12..20, through a disableable driver.
// - Row driver off while column selected; column held in a register.
// - Address path ten bits: nine for main DRAMs, one for parity DRAMs.
// - First pipelined read's data held while second waits at inputs.
// - Writes are posted: ready first, write data held afterwards.
// - One odd parity bit per byte lane, stored on writes, compared on reads.
// - Read parity mismatch raises fault; bus cycle not stopped or retried.
// - Extra address bit splits parity storage into four bank sections.
// - Five state variables, 15 states; sequences give read, write, refresh.
// - Next-address and ready come straight from the state machine.
// - Pipeline hold blocks other subsystems until pending cycles finish.
// - Bank row strobes decoded from bits 21..23 and state, one per bank.
// - Parity row strobe covers all memory, decoded from fewer address bits.
// - Column path runs on delayed clock, sampling state in same cycle.
// - Column path drives column enable, chip select, read data latch.
// - Row path drives row enable, output enable, remaining data controls.
// - Row path latches write parity and read parity error.
// - Write strobes clocked by latch pulse: asserted on writes, released.
// - Delayed clock is the system clock delayed by 20 ns.
// - Latch pulse captures byte lane enables, only in write cycles.
`default_nettype none
package dram_ctrl_pkg;

  // Clock rates and derived counts
  localparam int CORE_PERIOD_PS    = 10000;
  localparam int SYS_CLK_KHZ       = 33330;
  localparam int SYS_PERIOD_PS     = 1000000000 / SYS_CLK_KHZ;
  localparam int SYS_DIV           = SYS_PERIOD_PS / CORE_PERIOD_PS;
  localparam logic [1:0] SYS_DIV_LAST = 2'(SYS_DIV - 1);
  localparam int DELAYED_CLOCK_DELAY_NS     = 20;
  localparam int DELAYED_CLOCK_DELAY_CYC    =
    (DELAYED_CLOCK_DELAY_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int REFRESH_INTERVAL_NS = 15600;
  localparam int REFRESH_CYC       =
    REFRESH_INTERVAL_NS * 1000 / CORE_PERIOD_PS;
  localparam logic [10:0] REFRESH_LAST = 11'(REFRESH_CYC - 1);

  // Processor address fields
  localparam int ROW_LO      = 12;
  localparam int ROW_HI      = 20;
  localparam int COL_LO      = 3;
  localparam int COL_HI      = 11;
  localparam int BANK_LO     = 21;
  localparam int BANK_HI     = 22;
  localparam int BANK_TOP    = 23;
  localparam int PAR_ROW_BIT = 21;
  localparam int PAR_COL_BIT = 22;

  // Register map and fields
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_PARITY_EN_BIT  = 0;
  localparam int CTRL_REFRESH_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET  = 2'h3;
  localparam int STATUS_FAULT_BIT    = 0;
  localparam int STATUS_STATE_LO     = 1;
  localparam int STATUS_PEND_LO      = 6;
  localparam int STATUS_LANES_LO     = 8;
  localparam logic [1:0] PEND_MAX    = 2'h2;

  // Bus tracking states, five state variables
  typedef enum logic [4:0] {
    S_IDLE  = 5'h00,
    S_RROW  = 5'h01,
    S_RCOL  = 5'h02,
    S_RWAIT = 5'h03,
    S_RDATA = 5'h04,
    S_RDONE = 5'h05,
    S_WPOST = 5'h08,
    S_WROW  = 5'h09,
    S_WCOL  = 5'h0A,
    S_WEND  = 5'h0B,
    S_FROW  = 5'h10,
    S_FHOLD = 5'h11,
    S_PRE1  = 5'h18,
    S_PRE2  = 5'h19,
    S_PRE3  = 5'h1A
  } cycle_state_t;

endpackage
`default_nettype wire

// ### core/pipelined_dram_controller.sv
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module pipelined_dram_controller
(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                latchedCycleStart,
  input  wire logic                dramSelect,
  input  wire logic                writeNotRead,
  input  wire logic [23:3]         procAddr,
  input  wire logic [7:0]          byteLaneEnables_b,
  input  wire logic [63:0]         procDataIn,
  output logic      [63:0]         procDataOut,
  output logic                     procDataOe,
  input  wire logic [63:0]         dramDataIn,
  output logic      [63:0]         dramDataOut,
  output logic                     dramDataOe,
  input  wire logic [7:0]          parityIn,
  output logic      [7:0]          parityOut,
  output logic                     parityOe,
  output logic      [9:0]          rowAddrOut,
  output logic                     rowAddrDriveEn,
  output logic      [9:0]          colAddrOut,
  output logic                     colAddrDriveEn,
  output logic      [3:0]          bankRowStrobe,
  output logic                     parityRowStrobe,
  output logic                     masterChipSelect,
  output logic                     masterOutputEnable,
  output logic      [7:0]          byteWriteEn,
  output logic                     writeEnableLatchPulse,
  output logic                     memCycleReadyOut,
  output logic                     nextAddressRequest,
  output logic                     pipelineHold,
  output logic                     parityFault,
  input  wire logic [3:0]          regAddr,
  input  wire logic [31:0]         regWrData,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [31:0]         regRdData
);
  import dram_ctrl_pkg::*;

  dram_ctrl_pkg::cycle_state_t cycleStateMachine;
  dram_ctrl_pkg::cycle_state_t next_cycleStateMachine;

  logic [1:0]                divCount;
  logic                      sysTick;
  logic [DELAYED_CLOCK_DELAY_CYC-1:0] delayLine;
  logic                      delayedTick;
  logic [1:0]                pendingCount;
  logic                      startSeen;
  logic                      takeNext;
  logic                      consume;
  logic                      cycleIsWrite;
  logic [10:0]               refreshTimer;
  logic                      refreshDue;
  logic [8:0]                refreshRow;
  logic [1:0]                ctrl;
  logic [7:0]                faultLanes;
  logic [63:0]               readHold;
  logic [7:0]                readParity;
  logic [63:0]               writeHold;
  logic [7:0]                laneMismatch;
  logic                      rasActive;
  logic                      refreshActive;
  logic                      faultClear;

  // Odd parity bit for each byte lane
  function automatic logic [7:0] oddParity(input logic [63:0] data);
    logic [7:0] bits;
    bits = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      bits[i] = ~^data[i*8 +: 8];
    end
    return bits;
  endfunction

  // States in which the selected bank keeps its row strobe
  function automatic logic holdsRow(input cycle_state_t st);
    return (st == S_RROW) || (st == S_RCOL) || (st == S_RWAIT) ||
           (st == S_RDATA) || (st == S_RDONE) || (st == S_WROW) ||
           (st == S_WCOL) || (st == S_WEND);
  endfunction

  // System rate as an enable, one core cycle in three
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      divCount <= 2'h0;
    else if (divCount == SYS_DIV_LAST)
      divCount <= 2'h0;
    else
      divCount <= divCount + 2'h1;
  end

  assign sysTick = (divCount == SYS_DIV_LAST);

  // Delayed enable trails the system enable by the fixed delay
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      delayLine <= '0;
    else
      delayLine <= {delayLine[DELAYED_CLOCK_DELAY_CYC-2:0], sysTick};
  end

  assign delayedTick = delayLine[DELAYED_CLOCK_DELAY_CYC-1];

  // Request qualification and dispatch terms
  assign startSeen = latchedCycleStart && dramSelect;
  assign takeNext  = (pendingCount != 2'h0) || startSeen;
  assign consume   = (next_cycleStateMachine == S_RROW) ||
                     (next_cycleStateMachine == S_WPOST) ||
                     ((cycleStateMachine == S_RDONE) &&
                      (next_cycleStateMachine == S_RCOL));

  // Next state of the bus tracking machine
  always_comb
  begin
    next_cycleStateMachine = cycleStateMachine;
    case (cycleStateMachine)
      S_IDLE:
      begin
        if (startSeen)
          next_cycleStateMachine = writeNotRead ? S_WPOST : S_RROW;
        else if (refreshDue)
          next_cycleStateMachine = S_FROW;
      end
      S_RROW:  next_cycleStateMachine = S_RCOL;
      S_RCOL:  next_cycleStateMachine = S_RWAIT;
      S_RWAIT: next_cycleStateMachine = S_RDATA;
      S_RDATA: next_cycleStateMachine = S_RDONE;
      S_RDONE:
      begin
        // Pipelined read reuses the open row and column path
        if (takeNext && !writeNotRead)
          next_cycleStateMachine = S_RCOL;
        else
          next_cycleStateMachine = S_PRE1;
      end
      S_WPOST: next_cycleStateMachine = S_WROW;
      S_WROW:  next_cycleStateMachine = S_WCOL;
      S_WCOL:  next_cycleStateMachine = S_WEND;
      S_WEND:  next_cycleStateMachine = S_PRE1;
      S_FROW:  next_cycleStateMachine = S_FHOLD;
      S_FHOLD: next_cycleStateMachine = S_PRE1;
      S_PRE1:  next_cycleStateMachine = S_PRE2;
      S_PRE2:  next_cycleStateMachine = S_PRE3;
      S_PRE3:
      begin
        // Three ticks of precharge before any new row
        if (takeNext)
          next_cycleStateMachine = writeNotRead ? S_WPOST : S_RROW;
        else if (refreshDue)
          next_cycleStateMachine = S_FROW;
        else
          next_cycleStateMachine = S_IDLE;
      end
      default: next_cycleStateMachine = S_IDLE;
    endcase
  end

  // State variables and processor handshakes, all on the system tick
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cycleStateMachine  <= S_IDLE;
      memCycleReadyOut   <= 1'b0;
      nextAddressRequest <= 1'b0;
      pipelineHold       <= 1'b0;
    end
    else if (sysTick)
    begin
      cycleStateMachine <= next_cycleStateMachine;
      // Ready early on writes, the data is posted
      memCycleReadyOut <= (next_cycleStateMachine == S_RDONE) ||
                          (next_cycleStateMachine == S_WPOST);
      // Three and one ticks ahead of ready, never beyond two pending
      nextAddressRequest <= ((next_cycleStateMachine == S_RCOL) ||
                             (next_cycleStateMachine == S_RDATA)) &&
                            (pendingCount < PEND_MAX);
      pipelineHold <= (next_cycleStateMachine != S_IDLE) ||
                      (pendingCount != 2'h0) || startSeen;
    end
  end

  // Count of started but not yet dispatched cycles
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pendingCount <= 2'h0;
      cycleIsWrite <= 1'b0;
    end
    else if (sysTick)
    begin
      pendingCount <= 2'(pendingCount + {1'b0, startSeen} -
                         {1'b0, consume});
      if (consume)
        cycleIsWrite <= writeNotRead;
    end
  end

  // Refresh timer; a due flag set in the same cycle as its clear stays set
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      refreshTimer <= 11'h000;
      refreshDue   <= 1'b0;
      refreshRow   <= 9'h000;
    end
    else
    begin
      if (!ctrl[CTRL_REFRESH_EN_BIT] || refreshTimer == REFRESH_LAST)
        refreshTimer <= 11'h000;
      else
        refreshTimer <= refreshTimer + 11'h001;
      if (ctrl[CTRL_REFRESH_EN_BIT] && refreshTimer == REFRESH_LAST)
        refreshDue <= 1'b1;
      else if (sysTick && next_cycleStateMachine == S_FROW)
        refreshDue <= 1'b0;
      if (sysTick && cycleStateMachine == S_FHOLD)
        refreshRow <= refreshRow + 9'h001;
    end
  end

  // Bank and parity row strobes are a plain decode, no flops
  assign rasActive     = holdsRow(cycleStateMachine);
  assign refreshActive = (cycleStateMachine == S_FROW) ||
                         (cycleStateMachine == S_FHOLD);

  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      bankRowStrobe[b] = refreshActive ||
                         (rasActive && !procAddr[BANK_TOP] &&
                          (procAddr[BANK_HI:BANK_LO] == 2'(b)));
    end
  end

  // Only the top bit qualifies; one strobe spans all four banks
  assign parityRowStrobe = refreshActive ||
                           (rasActive && !procAddr[BANK_TOP]);

  // Row address buffer; parity DRAMs take bank bit as tenth row bit
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      rowAddrOut <= 10'h000;
    else if (refreshActive)
      rowAddrOut <= {1'b0, refreshRow};
    else
      rowAddrOut <= {procAddr[PAR_ROW_BIT],
                     procAddr[ROW_HI:ROW_LO]};
  end

  // Row path controls, decoded from state on the system tick
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rowAddrDriveEn     <= 1'b1;
      masterOutputEnable <= 1'b0;
      procDataOe         <= 1'b0;
      dramDataOe         <= 1'b0;
      parityOe           <= 1'b0;
    end
    else if (sysTick)
    begin
      // Held one tick past the row strobe; off until column drivers let go
      rowAddrDriveEn <= !((next_cycleStateMachine == S_RCOL) ||
                          (next_cycleStateMachine == S_RWAIT) ||
                          (next_cycleStateMachine == S_RDATA) ||
                          (next_cycleStateMachine == S_RDONE) ||
                          (next_cycleStateMachine == S_WCOL) ||
                          (next_cycleStateMachine == S_WEND) ||
                          (next_cycleStateMachine == S_PRE1 &&
                           colAddrDriveEn));
      masterOutputEnable <= (next_cycleStateMachine == S_RCOL) ||
                            (next_cycleStateMachine == S_RWAIT) ||
                            (next_cycleStateMachine == S_RDATA) ||
                            (next_cycleStateMachine == S_RDONE);
      procDataOe <= (next_cycleStateMachine == S_RDONE);
      dramDataOe <= (next_cycleStateMachine == S_WROW) ||
                    (next_cycleStateMachine == S_WCOL) ||
                    (next_cycleStateMachine == S_WEND);
      parityOe   <= (next_cycleStateMachine == S_WROW) ||
                    (next_cycleStateMachine == S_WCOL) ||
                    (next_cycleStateMachine == S_WEND);
    end
  end

  // Posted write data and its parity stay latched after ready
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      writeHold <= 64'h0000000000000000;
      parityOut <= 8'h00;
    end
    else if (sysTick && cycleStateMachine == S_WPOST)
    begin
      writeHold <= procDataIn;
      parityOut <= oddParity(procDataIn);
    end
  end

  assign dramDataOut = writeHold;

  // Column path on the delayed enable sees this tick's new state
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      colAddrDriveEn   <= 1'b0;
      masterChipSelect <= 1'b0;
      colAddrOut       <= 10'h000;
    end
    else if (delayedTick)
    begin
      colAddrDriveEn <= (cycleStateMachine == S_RCOL) ||
                        (cycleStateMachine == S_RWAIT) ||
                        (cycleStateMachine == S_RDATA) ||
                        (cycleStateMachine == S_RDONE) ||
                        (cycleStateMachine == S_WCOL) ||
                        (cycleStateMachine == S_WEND);
      // Early write: chip select alone times the DRAM write
      masterChipSelect <= (cycleStateMachine == S_RCOL) ||
                          (cycleStateMachine == S_RWAIT) ||
                          (cycleStateMachine == S_RDATA) ||
                          (cycleStateMachine == S_RDONE) ||
                          (cycleStateMachine == S_WCOL);
      // Latched so the pipelined next address cannot disturb it
      if (cycleStateMachine == S_RCOL || cycleStateMachine == S_WCOL)
        colAddrOut <= {procAddr[PAR_COL_BIT],
                       procAddr[COL_HI:COL_LO]};
    end
  end

  // Read data latch; the next read then waits at the DRAM side
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      readHold   <= 64'h0000000000000000;
      readParity <= 8'h00;
    end
    else if (delayedTick && cycleStateMachine == S_RDATA)
    begin
      readHold   <= dramDataIn;
      readParity <= parityIn;
    end
  end

  assign procDataOut = readHold;

  // Latch pulse at start and end of writes only
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      writeEnableLatchPulse <= 1'b0;
    else
      writeEnableLatchPulse <= delayedTick && cycleIsWrite &&
                               ((cycleStateMachine == S_WPOST) ||
                                (cycleStateMachine == S_WEND));
  end

  // Byte write strobes advance only on the latch pulse
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      byteWriteEn <= 8'h00;
    else if (writeEnableLatchPulse)
    begin
      if (cycleStateMachine == S_WPOST && cycleIsWrite)
        byteWriteEn <= ~byteLaneEnables_b;
      else
        byteWriteEn <= 8'h00;
    end
  end

  // Compare stored parity against the held read data
  assign laneMismatch = oddParity(readHold) ^ readParity;
  assign faultClear   = regWr && (regAddr == REG_STATUS) &&
                        regWrData[STATUS_FAULT_BIT];

  // Fault is flagged only; the cycle completes unchanged
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      parityFault <= 1'b0;
      faultLanes  <= 8'h00;
    end
    else if (sysTick && cycleStateMachine == S_RDONE &&
             ctrl[CTRL_PARITY_EN_BIT] && laneMismatch != 8'h00)
    begin
      parityFault <= 1'b1;
      faultLanes  <= laneMismatch;
    end
    else if (faultClear)
      parityFault <= 1'b0;
  end

  // Control register writes
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      ctrl <= CTRL_RESET;
    else if (regWr && regAddr == REG_CTRL)
      ctrl <= regWrData[1:0];
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      regRdData <= 32'h00000000;
    else if (regRd)
    begin
      case (regAddr)
        REG_CTRL:   regRdData <= {30'h00000000, ctrl};
        REG_STATUS: regRdData <= {16'h0000, faultLanes,
                                  pendingCount, cycleStateMachine,
                                  parityFault};
        default:    regRdData <= 32'h00000000;
      endcase
    end
    else
      regRdData <= 32'h00000000;
  end

endmodule
`default_nettype wire

// ### test/pipelined_dram_controller_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pipelined_dram_controller_chk
  import dram_ctrl_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        latchedCycleStart,
  input wire logic        dramSelect,
  input wire logic        writeNotRead,
  input wire logic [23:3] procAddr,
  input wire logic [7:0]  byteLaneEnables_b,
  input wire logic [63:0] dramDataOut,
  input wire logic [7:0]  parityOut,
  input wire logic        parityOe,
  input wire logic [9:0]  rowAddrOut,
  input wire logic        rowAddrDriveEn,
  input wire logic [9:0]  colAddrOut,
  input wire logic        colAddrDriveEn,
  input wire logic [3:0]  bankRowStrobe,
  input wire logic [7:0]  byteWriteEn,
  input wire logic        writeEnableLatchPulse,
  input wire logic        memCycleReadyOut,
  input wire logic        nextAddressRequest,
  input wire logic        pipelineHold,
  input wire logic        parityFault,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr
);
  logic [1:0] divCnt;
  logic       take;

  // Own copy of the system tick, so take moments are known at the ports
  always_ff @(posedge core_clk)
    if (!rst_b)
      divCnt <= 2'h0;
    else
      divCnt <= (divCnt == 2'h2) ? 2'h0 : divCnt + 2'h1;
  assign take = divCnt == 2'h2 && latchedCycleStart && dramSelect;

  // Every lane plus its bit must hold an odd count of ones
  function automatic logic oddOk(input logic [63:0] d, input logic [7:0] p);
    oddOk = 1'b1;
    for (int i = 0; i < 8; i++)
      if (!(^{p[i], d[8*i +: 8]}))
        oddOk = 1'b0;
  endfunction

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_rowcol_apart: assert property (
    !(rowAddrDriveEn && colAddrDriveEn)) else $error("both addresses driven");
  chk_row_field: assert property (
    $past(rst_b) && !$past(&bankRowStrobe)
    |-> rowAddrOut == {$past(procAddr[21]), $past(procAddr[20:12])})
    else $error("row address field wrong");
  chk_col_field: assert property (
    $rose(colAddrDriveEn) |-> colAddrOut == {procAddr[22], procAddr[11:3]})
    else $error("column address field wrong");
  chk_bank_pick: assert property (
    (|bankRowStrobe) && !(&bankRowStrobe)
    |-> bankRowStrobe == (4'h1 << procAddr[22:21]) && !procAddr[23])
    else $error("bank strobe decode wrong");
  chk_parity_odd: assert property (
    parityOe |-> oddOk(dramDataOut, parityOut)) else $error("write parity even");
  chk_ready_tick: assert property (
    $rose(memCycleReadyOut) |-> memCycleReadyOut[*3] ##1 !memCycleReadyOut)
    else $error("ready not one system tick");
  chk_write_post: assert property (
    take && writeNotRead && !pipelineHold |=> memCycleReadyOut[*3])
    else $error("posted write ready late");
  chk_read_wait: assert property (
    take && !writeNotRead && !pipelineHold
    |-> !memCycleReadyOut[*8] ##1 !memCycleReadyOut[*5] ##1 memCycleReadyOut)
    else $error("read ready timing wrong");
  chk_next_ahead: assert property (
    $rose(nextAddressRequest) |-> ##[3:9] $rose(memCycleReadyOut))
    else $error("next address not ahead of ready");
  chk_fault_stays: assert property (
    parityFault && !(regWr && regAddr == REG_STATUS && regWrData[0])
    |=> parityFault) else $error("parity fault dropped");
  chk_lane_capture: assert property (
    writeEnableLatchPulse |=> byteWriteEn == ($past(memCycleReadyOut) ?
      ~$past(byteLaneEnables_b) : 8'h00))
    else $error("byte enables not captured");
endmodule

bind pipelined_dram_controller pipelined_dram_controller_chk chk
(
  .core_clk, .rst_b, .latchedCycleStart, .dramSelect, .writeNotRead,
  .procAddr, .byteLaneEnables_b, .dramDataOut, .parityOut, .parityOe,
  .rowAddrOut, .rowAddrDriveEn, .colAddrOut, .colAddrDriveEn,
  .bankRowStrobe, .byteWriteEn, .writeEnableLatchPulse, .memCycleReadyOut,
  .nextAddressRequest, .pipelineHold,
  .parityFault, .regAddr, .regWrData, .regWr
);
`default_nettype wire

// ### test/proc_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module proc_bus_master
(
  input  wire logic        core_clk,
  input  wire logic        memCycleReadyOut,
  output logic             latchedCycleStart,
  output logic             dramSelect,
  output logic             writeNotRead,
  output logic [23:3]      procAddr,
  output logic [7:0]       byteLaneEnables_b,
  output logic [63:0]      procDataIn
);
  // Bus quiet at time zero
  initial
  begin
    latchedCycleStart = 1'b0;
    dramSelect = 1'b0;
    writeNotRead = 1'b0;
    procAddr = '0;
    byteLaneEnables_b = 8'hFF;
    procDataIn = '0;
  end

  // Start held a full system period so exactly one tick samples it
  task automatic cycle(input logic w, input logic [23:3] a,
                       input logic [63:0] d, input logic [7:0] lb);
    int n;
    n = 0;
    @(posedge core_clk);
    writeNotRead <= w;
    procAddr <= a;
    procDataIn <= d;
    byteLaneEnables_b <= lb;
    latchedCycleStart <= 1'b1;
    dramSelect <= 1'b1;
    repeat (3) @(posedge core_clk);
    latchedCycleStart <= 1'b0;
    dramSelect <= 1'b0;
    while (memCycleReadyOut !== 1'b1 && n < 60)
    begin
      @(posedge core_clk);
      n++;
    end
    while (memCycleReadyOut === 1'b1)
      @(posedge core_clk);
    // Released data bus shows a changed pattern, not the old word
    procDataIn <= ~d;
    repeat (24) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ### test/pipelined_dram_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pipelined_dram_controller_tb;
  import dram_ctrl_pkg::*;
  logic        core_clk, rst_b, regWr, regRd, rdPend, oePrev, wrPrev;
  logic        latchedCycleStart, dramSelect, writeNotRead, procDataOe;
  logic        dramDataOe, masterOutputEnable, memCycleReadyOut, parityFault;
  logic [3:0]  regAddr;
  logic [31:0] regWrData, regRdData;
  logic [23:3] procAddr, a;
  logic [7:0]  byteLaneEnables_b, byteWriteEn, memPar, lb;
  logic [63:0] procDataIn, procDataOut, dramDataOut, memWord, d, e;
  logic [71:0] w;
  logic [63:0] expReg[$], expData[$];
  logic [71:0] expWr[$];
  int          failCount, checksDone, cycles, seed;

  proc_bus_master mdl (.core_clk, .memCycleReadyOut, .latchedCycleStart,
    .dramSelect, .writeNotRead, .procAddr, .byteLaneEnables_b, .procDataIn);

  pipelined_dram_controller DUT (.core_clk, .rst_b, .latchedCycleStart,
    .dramSelect, .writeNotRead, .procAddr, .byteLaneEnables_b, .procDataIn,
    .procDataOut, .procDataOe,
    .dramDataIn(masterOutputEnable ? memWord : ~memWord), .dramDataOut,
    .dramDataOe, .parityIn(masterOutputEnable ? memPar : ~memPar),
    .parityOut(), .parityOe(), .rowAddrOut(), .rowAddrDriveEn(),
    .colAddrOut(), .colAddrDriveEn(), .bankRowStrobe(), .parityRowStrobe(),
    .masterChipSelect(), .masterOutputEnable, .byteWriteEn,
    .writeEnableLatchPulse(), .memCycleReadyOut, .nextAddressRequest(),
    .pipelineHold(), .parityFault, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (failCount == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One strobe cycle; reads note value and mask for the monitor
  task automatic regAcc(input logic wr, input logic [3:0] ad,
                        input logic [31:0] v, input logic [31:0] m);
    @(posedge core_clk);
    regAddr <= ad;
    regWrData <= v;
    regWr <= wr;
    regRd <= !wr;
    if (!wr)
      expReg.push_back({m, v & m});
    @(posedge core_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
  endtask

  function automatic logic [7:0] oddPar(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
      oddPar[i] = ~^v[8*i +: 8];
  endfunction

  // Results are taken off the queues oldest first as they appear
  always @(posedge core_clk)
  begin
    rdPend <= regRd;
    oePrev <= procDataOe;
    wrPrev <= dramDataOe;
    if (rdPend === 1'b1)
    begin
      e = expReg.pop_front();
      cmp(regRdData & e[63:32], e[31:0]);
    end
    if (procDataOe === 1'b1 && oePrev === 1'b0)
      cmp(procDataOut, expData.pop_front());
    if (dramDataOe === 1'b1 && wrPrev === 1'b0)
    begin
      w = expWr.pop_front();
      cmp(dramDataOut, w[63:0]);
      cmp(byteWriteEn, w[71:64]);
    end
  end

  // Cuts a hang short, well beyond the refresh wait and the cycles around it
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failCount++;
      summarize();
    end
  end

  initial
  begin
    rst_b = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    oePrev = 1'b0;
    wrPrev = 1'b0;
    memWord = '0;
    memPar = 8'h00;
    seed = 18;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    // Reset value, then parity on and refresh off; unmapped places inert
    regAcc(1'b0, REG_CTRL, 32'h3, 32'h3);
    regAcc(1'b1, REG_CTRL, 32'h1, 32'h0);
    regAcc(1'b1, 4'hC, 32'hFF, 32'h0);
    regAcc(1'b0, REG_CTRL, 32'h1, 32'h3);
    regAcc(1'b0, 4'h8, 32'h0, 32'hFFFFFFFF);
    // Write then read back in every bank; last read has a bad lane 2
    for (int i = 0; i < 4; i++)
    begin
      a = {1'b0, i[1:0], 18'($random(seed))};
      d = {$random(seed), $random(seed)};
      lb = 8'($random(seed));
      expWr.push_back({~lb, d});
      mdl.cycle(1'b1, a, d, lb);
      memWord <= ~d;
      memPar <= oddPar(~d) ^ ((i == 3) ? 8'h04 : 8'h00);
      expData.push_back(~d);
      mdl.cycle(1'b0, a, 64'h0, 8'hFF);
    end
    regAcc(1'b0, REG_STATUS, 32'h401, 32'hFF01);
    cmp(parityFault, 1'b1);
    regAcc(1'b1, REG_STATUS, 32'h1, 32'h0);
    regAcc(1'b0, REG_STATUS, 32'h0, 32'h1);
    // Refresh on; a read after the first refresh still returns its word
    regAcc(1'b1, REG_CTRL, 32'h3, 32'h0);
    repeat (1700) @(posedge core_clk);
    expData.push_back(memWord);
    mdl.cycle(1'b0, a, 64'h0, 8'hFF);
    repeat (4) @(posedge core_clk);
    cmp(expReg.size() + expData.size() + expWr.size(), 0);
    summarize();
  end
endmodule
`default_nettype wire
